/* pic_config.sv */
// pressure event interrupt configuration register and interrupt source logic
`timescale 1ns/100ps
// How it works
// - auto reference enable bit, resets to zero
// - auto reference clear bit, resets to zero
// - auto zero enable bit, resets to zero
// - auto zero clear bit, resets to zero
// - master enable gates new low and high events, not source bits already latched
// - latch select holds events in source register
// - low event enable requests low interrupts
// - high event enable requests high interrupts
// - config register read write at 0Bh
module pic_config (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic press_low_evt,
	input wire logic press_high_evt,
	output pic_pkg::pic_cfg_t cfg,
	output logic auto_reference_clear,
	output logic auto_zero_clear,
	output logic press_irq
);
	// ************************************************
	// state
	// ************************************************
	pic_pkg::pic_cfg_t cfg_r;
	pic_pkg::pic_cfg_t cfg_nxt;
	logic aref_clr_r;
	logic aref_clr_nxt;
	logic az_clr_r;
	logic az_clr_nxt;
	logic [2:0] src_r;
	logic [2:0] src_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic wr_cfg;
	logic rd_cfg;
	logic rd_src;
	logic low_hit;
	logic high_hit;
	logic [7:0] cfg_view;

	// address decode of the internal register port
	assign wr_cfg = reg_wr && (reg_addr == pic_pkg::PIC_ADDR_CFG);
	assign rd_cfg = reg_rd && (reg_addr == pic_pkg::PIC_ADDR_CFG);
	assign rd_src = reg_rd && (reg_addr == pic_pkg::PIC_ADDR_SRC);

	// read view: clear bits always read back as zero, they are never stored
	always_comb begin
		cfg_view = pic_pkg::PIC_CFG_RESET;
		cfg_view[pic_pkg::PIC_BIT_AREF_EN] = cfg_r.auto_reference_enable;
		cfg_view[pic_pkg::PIC_BIT_AZ_EN] = cfg_r.auto_zero_enable;
		cfg_view[pic_pkg::PIC_BIT_GEN_EN] = cfg_r.irq_generation_enable;
		cfg_view[pic_pkg::PIC_BIT_LATCH] = cfg_r.irq_latch_select;
		cfg_view[pic_pkg::PIC_BIT_LOW_EN] = cfg_r.low_event_enable;
		cfg_view[pic_pkg::PIC_BIT_HIGH_EN] = cfg_r.high_event_enable;
	end

	// ************************************************
	// configuration register
	// ************************************************
	// next configuration and the one cycle clear commands
	always_comb begin
		cfg_nxt = cfg_r;
		aref_clr_nxt = 1'b0;
		az_clr_nxt = 1'b0;
		if (wr_cfg) begin
			cfg_nxt.auto_reference_enable = reg_wdata[pic_pkg::PIC_BIT_AREF_EN];
			cfg_nxt.auto_zero_enable = reg_wdata[pic_pkg::PIC_BIT_AZ_EN];
			cfg_nxt.irq_generation_enable = reg_wdata[pic_pkg::PIC_BIT_GEN_EN];
			cfg_nxt.irq_latch_select = reg_wdata[pic_pkg::PIC_BIT_LATCH];
			cfg_nxt.low_event_enable = reg_wdata[pic_pkg::PIC_BIT_LOW_EN];
			cfg_nxt.high_event_enable = reg_wdata[pic_pkg::PIC_BIT_HIGH_EN];
			aref_clr_nxt = reg_wdata[pic_pkg::PIC_BIT_AREF_CLR];
			az_clr_nxt = reg_wdata[pic_pkg::PIC_BIT_AZ_CLR];
		end
	end

	// configuration flops
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cfg_r <= pic_pkg::PIC_CFG_DEFAULT;
			aref_clr_r <= 1'b0;
			az_clr_r <= 1'b0;
		end else begin
			cfg_r <= cfg_nxt;
			aref_clr_r <= aref_clr_nxt;
			az_clr_r <= az_clr_nxt;
		end
	end

	// ************************************************
	// interrupt source
	// ************************************************
	// event qualification; the master enable gates both thresholds
	assign low_hit = press_low_evt && cfg_r.low_event_enable && cfg_r.irq_generation_enable;
	assign high_hit = press_high_evt && cfg_r.high_event_enable && cfg_r.irq_generation_enable;

	// latched mode keeps bits until read; a new event in the read cycle wins over the clear
	always_comb begin
		src_nxt = pic_pkg::PIC_SRC_RESET;
		if (cfg_r.irq_latch_select) begin
			if (!rd_src) begin
				src_nxt = src_r;
			end
			src_nxt[pic_pkg::PIC_SRC_LOW] = src_nxt[pic_pkg::PIC_SRC_LOW] | low_hit;
			src_nxt[pic_pkg::PIC_SRC_HIGH] = src_nxt[pic_pkg::PIC_SRC_HIGH] | high_hit;
		end else begin
			src_nxt[pic_pkg::PIC_SRC_LOW] = low_hit;
			src_nxt[pic_pkg::PIC_SRC_HIGH] = high_hit;
		end
		src_nxt[pic_pkg::PIC_SRC_ACTIVE] = src_nxt[pic_pkg::PIC_SRC_LOW] | src_nxt[pic_pkg::PIC_SRC_HIGH];
	end

	// source flops
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			src_r <= pic_pkg::PIC_SRC_RESET;
		end else begin
			src_r <= src_nxt;
		end
	end

	// ************************************************
	// read data
	// ************************************************
	// read data holds until the next read; unmapped addresses read zero
	always_comb begin
		rdata_nxt = rdata_r;
		if (rd_cfg) begin
			rdata_nxt = cfg_view;
		end else if (rd_src) begin
			rdata_nxt = {5'h0, src_r};
		end else if (reg_rd) begin
			rdata_nxt = pic_pkg::PIC_RDATA_RESET;
		end
	end

	// read data flops
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdata_r <= pic_pkg::PIC_RDATA_RESET;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// outputs straight from flops
	assign reg_rdata = rdata_r;
	assign cfg = cfg_r;
	assign auto_reference_clear = aref_clr_r;
	assign auto_zero_clear = az_clr_r;
	assign press_irq = src_r[pic_pkg::PIC_SRC_ACTIVE];

	// ************************************************
	// assertions
	// ************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_aref_en_write: assert property (wr_cfg |=> cfg.auto_reference_enable == $past(reg_wdata[7]))
		else $error("auto reference enable not written");
	a_aref_clr_pulse: assert property (wr_cfg && reg_wdata[6] |=> auto_reference_clear ##1
		auto_reference_clear == $past(wr_cfg && reg_wdata[6]))
		else $error("auto reference clear not a single pulse");
	a_az_en_write: assert property (wr_cfg |=> cfg.auto_zero_enable == $past(reg_wdata[5]))
		else $error("auto zero enable not written");
	a_az_clr_pulse: assert property (auto_zero_clear |-> $past(wr_cfg && reg_wdata[4]))
		else $error("auto zero clear without command");
	a_gen_gate: assert property (!cfg.irq_generation_enable && !cfg.irq_latch_select |=> !press_irq)
		else $error("interrupt with generation disabled");
	a_latch_hold: assert property (cfg.irq_latch_select && press_irq && !rd_src && !wr_cfg |=> press_irq)
		else $error("latched interrupt dropped");
	a_low_event: assert property (low_hit |=> src_r[1] && press_irq)
		else $error("low event not flagged");
	a_high_event: assert property (!cfg.high_event_enable && !cfg.irq_latch_select |=> !src_r[0])
		else $error("high event flagged while disabled");
	a_cfg_readback: assert property (rd_cfg |=> reg_rdata == $past(cfg_view) && reg_rdata[6] == 1'b0)
		else $error("config readback wrong");
	a_read_clear: assert property (cfg.irq_latch_select && rd_src && !low_hit && !high_hit |=> src_r == 3'h0)
		else $error("source not cleared by read");
	a_clr_selfclr: assert property (auto_reference_clear |-> $past(wr_cfg && reg_wdata[6]))
		else $error("clear command lingered");

	// ************************************************
	// field writes, holds and source reads
	// ************************************************
	// back to back writes are legal, so holds are checked per cycle rather than over a window
	a_gen_write: assert property (wr_cfg |=>
		cfg.irq_generation_enable == $past(reg_wdata[pic_pkg::PIC_BIT_GEN_EN]))
		else $error("generation enable not written");
	a_latch_write: assert property (wr_cfg |=>
		cfg.irq_latch_select == $past(reg_wdata[pic_pkg::PIC_BIT_LATCH]))
		else $error("latch select not written");
	a_low_en_write: assert property (wr_cfg |=>
		cfg.low_event_enable == $past(reg_wdata[pic_pkg::PIC_BIT_LOW_EN]))
		else $error("low event enable not written");
	a_high_en_write: assert property (wr_cfg |=>
		cfg.high_event_enable == $past(reg_wdata[pic_pkg::PIC_BIT_HIGH_EN]))
		else $error("high event enable not written");
	a_az_clr_set: assert property (wr_cfg && reg_wdata[pic_pkg::PIC_BIT_AZ_CLR] |=>
		auto_zero_clear)
		else $error("auto zero clear command lost");
	a_cfg_hold: assert property (!wr_cfg |=> $stable(cfg))
		else $error("configuration changed without a write");
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");
	a_unmapped_zero: assert property (reg_rd && !rd_cfg && !rd_src |=>
		reg_rdata == pic_pkg::PIC_RDATA_RESET)
		else $error("unmapped read not zero");
	a_src_readback: assert property (rd_src |=>
		reg_rdata == {5'h00, $past(src_r)})
		else $error("source read not the pre clear value");
	a_set_wins: assert property (cfg.irq_latch_select && rd_src && low_hit |=>
		src_r[pic_pkg::PIC_SRC_LOW])
		else $error("event lost to a source read");
	a_live_follow: assert property (!cfg.irq_latch_select |=>
		src_r[pic_pkg::PIC_SRC_LOW] == $past(low_hit))
		else $error("live source does not follow event");

	c_latched_irq: cover property (cfg.irq_latch_select && low_hit ##[1:20] rd_src);
	c_live_high: cover property (!cfg.irq_latch_select && high_hit ##1 press_irq);
	c_both_clears: cover property (auto_reference_clear && auto_zero_clear);
	c_set_wins: cover property (rd_src && cfg.irq_latch_select && low_hit);
	// a read of an unmapped place must still answer
	c_unmapped_read: cover property (reg_rd && !rd_cfg && !rd_src);
endmodule

/* pic_host_model.sv */
// host model driving the register strobe port
`timescale 1ns/100ps
module pic_host_model (
	input wire logic core_clk,
	output logic [6:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	// idle bus shows inverted last values so stale data never looks valid
	initial begin
		reg_addr = 7'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	// one strobe cycle per byte, released after the sampling edge
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// read data is taken once the strobe edge has landed
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(negedge core_clk);
		d = reg_rdata;
	endtask
endmodule

/* pic_pkg.sv */
// constants and types for the pressure interrupt configuration block
package pic_pkg;
	// ************************************************
	// register map
	// ************************************************
	localparam logic [6:0] PIC_ADDR_CFG = 7'h0B;
	localparam logic [6:0] PIC_ADDR_SRC = 7'h24;
	localparam logic [7:0] PIC_CFG_RESET = 8'h00;
	localparam logic [2:0] PIC_SRC_RESET = 3'h0;
	localparam logic [7:0] PIC_RDATA_RESET = 8'h00;

	// ************************************************
	// configuration field positions
	// ************************************************
	localparam int PIC_BIT_AREF_EN = 7;
	localparam int PIC_BIT_AREF_CLR = 6;
	localparam int PIC_BIT_AZ_EN = 5;
	localparam int PIC_BIT_AZ_CLR = 4;
	localparam int PIC_BIT_GEN_EN = 3;
	localparam int PIC_BIT_LATCH = 2;
	localparam int PIC_BIT_LOW_EN = 1;
	localparam int PIC_BIT_HIGH_EN = 0;

	// ************************************************
	// source field positions
	// ************************************************
	localparam int PIC_SRC_ACTIVE = 2;
	localparam int PIC_SRC_LOW = 1;
	localparam int PIC_SRC_HIGH = 0;

	// stored configuration; the two clear bits are commands and are not held
	typedef struct packed {
		logic auto_reference_enable;
		logic auto_zero_enable;
		logic irq_generation_enable;
		logic irq_latch_select;
		logic low_event_enable;
		logic high_event_enable;
	} pic_cfg_t;

	localparam pic_cfg_t PIC_CFG_DEFAULT = '{default: 1'b0};
endpackage

/* tb_top.sv */
// self-checking bench for the pressure interrupt configuration block
`timescale 1ns/100ps
module tb_top;
	logic core_clk;
	logic rst_n;
	logic press_low_evt;
	logic press_high_evt;
	logic [6:0] reg_addr;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	pic_pkg::pic_cfg_t cfg;
	logic auto_reference_clear;
	logic auto_zero_clear;
	logic press_irq;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [7:0] d;
	logic [7:0] v;

	pic_config dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .press_low_evt(press_low_evt),
		.press_high_evt(press_high_evt), .cfg(cfg), .auto_reference_clear(auto_reference_clear),
		.auto_zero_clear(auto_zero_clear), .press_irq(press_irq));
	pic_host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// ************************************************
	// checking and closing
	// ************************************************
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test();
		if (num_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// a hung handshake would stall forever, so cap the run
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			end_of_test();
		end
	end
	// comparator levels change at an edge; source takes them one edge later
	task automatic evt(input logic l, input logic h);
		@(posedge core_clk);
		press_low_evt <= l;
		press_high_evt <= h;
		@(posedge core_clk);
		@(negedge core_clk);
	endtask

	initial begin
		rst_n = 1'b0;
		press_low_evt = 1'b0;
		press_high_evt = 1'b0;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		host.rd(pic_pkg::PIC_ADDR_CFG, d);
		chk("cfg reset", d, 8'h00);
		// walk a one through every field; clear bits pulse and read back zero
		for (int i = 0; i < 8; i++) begin
			v = 8'h01 << i;
			host.wr(pic_pkg::PIC_ADDR_CFG, v);
			@(negedge core_clk);
			chk("ref clear", {7'h00, auto_reference_clear}, {7'h00, v[6]});
			chk("zero clear", {7'h00, auto_zero_clear}, {7'h00, v[4]});
			chk("cfg out", {2'b00, cfg}, {2'b00, v[7], v[5], v[3:0]});
			@(negedge core_clk);
			chk("clear pulse", {6'h00, auto_reference_clear, auto_zero_clear}, 8'h00);
			host.rd(pic_pkg::PIC_ADDR_CFG, d);
			chk("cfg read", d, v & 8'haf);
		end
		// source is read-only and unmapped places read zero
		host.wr(pic_pkg::PIC_ADDR_SRC, 8'hff);
		host.rd(7'h10, d);
		chk("unmapped", d, 8'h00);
		host.rd(pic_pkg::PIC_ADDR_CFG, d);
		chk("cfg kept", d, 8'h80);
		// live mode with only the low event enabled
		host.wr(pic_pkg::PIC_ADDR_CFG, 8'h0a);
		evt(1'b1, 1'b1);
		chk("irq live", {7'h00, press_irq}, 8'h01);
		host.rd(pic_pkg::PIC_ADDR_SRC, d);
		chk("src live", d, 8'h06);
		evt(1'b0, 1'b0);
		chk("irq follows", {7'h00, press_irq}, 8'h00);
		// master enable off blocks both events
		host.wr(pic_pkg::PIC_ADDR_CFG, 8'h03);
		evt(1'b1, 1'b1);
		chk("irq gated", {7'h00, press_irq}, 8'h00);
		// latched high event holds until the source is read
		host.wr(pic_pkg::PIC_ADDR_CFG, 8'h0d);
		evt(1'b0, 1'b1);
		evt(1'b0, 1'b0);
		chk("irq held", {7'h00, press_irq}, 8'h01);
		host.rd(pic_pkg::PIC_ADDR_SRC, d);
		chk("src latched", d, 8'h05);
		chk("irq cleared", {7'h00, press_irq}, 8'h00);
		host.rd(pic_pkg::PIC_ADDR_SRC, d);
		chk("src empty", d, 8'h00);
		// both clears at once, then a low event still high during a latched read
		host.wr(pic_pkg::PIC_ADDR_CFG, 8'h5f);
		@(negedge core_clk);
		chk("both clears", {6'h00, auto_reference_clear, auto_zero_clear}, 8'h03);
		chk("cfg 5f", {2'b00, cfg}, 8'h0f);
		evt(1'b1, 1'b0);
		host.rd(pic_pkg::PIC_ADDR_SRC, d);
		chk("src set", d, 8'h06);
		chk("set wins", {7'h00, press_irq}, 8'h01);
		end_of_test();
	end
endmodule
